// file: logic/loop_detector_call_control.sv
`timescale 1ns/1ns
`include "loop_det_map.svh"
module loop_detector_call_control #(
	parameter int TENTH_CYC = `TENTH_CYC,
	parameter int DEBOUNCE_CYC = `DEBOUNCE_CYC,
	parameter int FAIL_CNT_W = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// front panel and controller pins
	input wire logic [2:0] buttons,
	input wire logic phase_green,
	// loop measurement, same clock
	input wire logic loop_occupied,
	input wire logic loop_fault_low,
	input wire logic loop_fault_high,
	// call and indicators
	output logic call_out,
	output logic detect_led,
	output logic backlight,
	output logic display_test,
	output logic loop_fail_msg,
	output logic fail_low,
	output logic fail_high,
	output logic restore_active,
	output logic [5:0] restore_left,
	output logic tuned,
	output logic full_sens,
	output logic green_comp,
	output logic audible,
	output logic retune
);
	generate
		if (TENTH_CYC < 1 || DEBOUNCE_CYC < 1 || FAIL_CNT_W < 1 || FAIL_CNT_W > 32) begin : g_chk
			$error("loop_detector_call_control: bad parameter");
		end
	endgenerate

	loop_det_pkg::cfg_t cfg_r;
	loop_det_pkg::diag_t diag_r;
	logic [31:0] tenth_cnt_r;
	logic tick_r;
	logic [3:0] raw_s1_r, raw_s2_r, deb_r;
	logic [31:0] deb_cnt_r [4];
	logic [2:0] btn, btn_d_r;
	logic green, occ_d_r, det_d_r, fail_d_r;
	logic [7:0] ext_r, dly_r;
	logic gap_r, discon_r, alert_r, det_rst_r;
	logic [3:0] burst_r;
	logic [FAIL_CNT_W-1:0] fail_cnt_r;
	logic [8:0] tune_r;
	logic [13:0] light_r;
	logic [4:0] hold_r;
	logic [5:0] rest_r;
	logic dis_mode, ext_hold, ext_allow, dly_start, det_now, det_fall, call_nxt, ext_run;
	logic occ_rise, fail_now, fail_rise, press, function_button_only, all3, two;
	logic function_button_fire, restore_fire, rst_req, burst_on;
	logic apb_setup, wr_en, cfg_reset;
	logic [31:0] rd_nxt;
	loop_det_pkg::cfg_t cfg_wr;

	// only the word offsets below answer; the rest signal pslverr
	function automatic logic is_mapped(input logic [7:0] a);
		return a == `OFS_CONFIG || a == `OFS_DIAG || a == `OFS_STATUS ||
			a == `OFS_FAILCNT || a == `OFS_CTRL;
	endfunction

	// ----------------------------------------------------------------
	// time base and input conditioning
	// ----------------------------------------------------------------
	// tenth-second tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tenth_cnt_r <= 32'h0000_0000;
			tick_r <= 1'b0;
		end else if (tenth_cnt_r == 32'(TENTH_CYC - 1)) begin
			tenth_cnt_r <= 32'h0000_0000;
			tick_r <= 1'b1;
		end else begin
			tenth_cnt_r <= tenth_cnt_r + 32'h0000_0001;
			tick_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_s1_r <= 4'h0;
			raw_s2_r <= 4'h0;
		end else begin
			raw_s1_r <= {phase_green, buttons};
			raw_s2_r <= raw_s1_r;
		end
	end

	// debounce: a level must hold steady for the whole window
	for (genvar i = 0; i < 4; i++) begin : g_deb
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				deb_cnt_r[i] <= 32'h0000_0000;
				deb_r[i] <= 1'b0;
			end else if (raw_s2_r[i] == deb_r[i]) begin
				deb_cnt_r[i] <= 32'h0000_0000;
			end else if (deb_cnt_r[i] == 32'(DEBOUNCE_CYC - 1)) begin
				deb_cnt_r[i] <= 32'h0000_0000;
				deb_r[i] <= raw_s2_r[i];
			end else begin
				deb_cnt_r[i] <= deb_cnt_r[i] + 32'h0000_0001;
			end
		end
	end

	assign btn = deb_r[2:0];
	assign green = deb_r[3];

	// edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			btn_d_r <= 3'h0;
			occ_d_r <= 1'b0;
			det_d_r <= 1'b0;
			fail_d_r <= 1'b0;
		end else begin
			btn_d_r <= btn;
			occ_d_r <= loop_occupied;
			det_d_r <= det_now;
			fail_d_r <= fail_now;
		end
	end

	// ----------------------------------------------------------------
	// call path
	// ----------------------------------------------------------------
	// green overrides delay and enables disconnect
	always_comb begin
		occ_rise = loop_occupied & !occ_d_r;
		fail_now = loop_fault_low | loop_fault_high;
		fail_rise = fail_now & !fail_d_r;
		dis_mode = cfg_r.dis_en & green;
		// type off holds; type on: timer does not hold the call
		ext_hold = !(dis_mode & cfg_r.dis_type);
		ext_allow = dis_mode | !(cfg_r.ext_green_only & !green);
		dly_start = occ_rise & (cfg_r.delay != 8'h00) & !green;
		det_now = tuned & loop_occupied & !dly_start & ((dly_r == 8'h00) | green);
		det_fall = det_d_r & !det_now;
		// counts the loading cycle too, so the call has no gap as detection ends
		ext_run = (ext_r != 8'h00) | (det_fall & ext_allow & (cfg_r.ext != 8'h00));
		call_nxt = fail_now | (!discon_r & (det_now | (ext_hold & ext_run)));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_r <= 8'h00;
		end else if (det_rst_r || green || !loop_occupied) begin
			dly_r <= 8'h00;
		end else if (dly_start) begin
			dly_r <= cfg_r.delay;
		end else if (tick_r && dly_r != 8'h00) begin
			dly_r <= dly_r - 8'h01;
		end
	end

	// extension counts down from full value in tenths
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_r <= 8'h00;
		end else if (det_rst_r || det_now) begin
			ext_r <= 8'h00;
		end else if (det_fall && ext_allow) begin
			ext_r <= cfg_r.ext;
		end else if (tick_r && ext_r != 8'h00) begin
			ext_r <= ext_r - 8'h01;
		end
	end

	// gap timing after each detection under green
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_r <= 1'b0;
		end else if (!dis_mode || det_now || discon_r) begin
			gap_r <= 1'b0;
		end else if (det_fall) begin
			gap_r <= 1'b1;
		end
	end

	// suppression lifted as soon as green ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			discon_r <= 1'b0;
		end else if (!dis_mode) begin
			discon_r <= 1'b0;
		end else if (gap_r && ext_r == 8'h00 && !det_now) begin
			discon_r <= 1'b1;
		end
	end

	// call, led and side outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			call_out <= 1'b0;
			detect_led <= 1'b0;
			green_comp <= 1'b0;
			audible <= 1'b0;
		end else begin
			call_out <= call_nxt;
			// led shows the alert burst while latched, else call, timing or fault
			detect_led <= alert_r ? burst_on :
				(call_nxt | (dly_r != 8'h00) | (ext_hold & ext_run) | fail_now);
			green_comp <= cfg_r.green_comp_en & green & call_out;
			// actual occupancy only, timing ignored
			audible <= diag_r.audible & loop_occupied;
		end
	end

	// ----------------------------------------------------------------
	// loop fault monitor
	// ----------------------------------------------------------------
	// message follows the fault; type shown; clears when the fault heals
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_fail_msg <= 1'b0;
			fail_low <= 1'b0;
			fail_high <= 1'b0;
		end else begin
			loop_fail_msg <= fail_now;
			fail_low <= loop_fault_low;
			fail_high <= loop_fault_high;
		end
	end

	// alert latch, a new failure wins over a reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alert_r <= 1'b0;
			burst_r <= 4'h0;
		end else begin
			if (fail_rise) begin
				alert_r <= 1'b1;
			end else if (det_rst_r) begin
				alert_r <= 1'b0;
			end
			if (fail_rise || (tick_r && burst_r == 4'(`BURST_T - 1))) begin
				burst_r <= 4'h0;
			end else if (tick_r) begin
				burst_r <= burst_r + 4'h1;
			end
		end
	end

	assign burst_on = (burst_r < 4'(2 * `BURST_FLASHES)) & !burst_r[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fail_cnt_r <= '0;
		end else if (det_rst_r) begin
			fail_cnt_r <= fail_rise ? FAIL_CNT_W'(1) : '0;
		end else if (fail_rise && fail_cnt_r != '1) begin
			fail_cnt_r <= fail_cnt_r + FAIL_CNT_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// tuning, panel gestures and backlight
	// ----------------------------------------------------------------
	// tuning milestones after any reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tune_r <= 9'h000;
			tuned <= 1'b0;
			full_sens <= 1'b0;
			retune <= 1'b0;
		end else begin
			retune <= det_rst_r;
			tuned <= tune_r >= 9'(`TUNE_T);
			full_sens <= tune_r == 9'(`FULL_SENS_T);
			if (det_rst_r) begin
				tune_r <= 9'h000;
			end else if (tick_r && tune_r != 9'(`FULL_SENS_T)) begin
				tune_r <= tune_r + 9'h001;
			end
		end
	end

	always_comb begin
		press = |(btn & ~btn_d_r);
		function_button_only = btn == 3'h1;
		all3 = &btn;
		two = (btn == 3'h3) | (btn == 3'h5) | (btn == 3'h6);
		function_button_fire = function_button_only & tick_r & (hold_r == 5'(`FUNCTION_BUTTON_HOLD_T - 1));
		restore_fire = all3 & tick_r & (rest_r == 6'(`RESTORE_T - 1));
		rst_req = cfg_reset | function_button_fire | restore_fire |
			(wr_en && paddr == `OFS_CTRL && pwdata[`CTRL_RESET_BIT]);
	end

	// function hold and restore timers, release aborts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_r <= 5'h00;
			rest_r <= 6'h00;
		end else begin
			if (!function_button_only) begin
				hold_r <= 5'h00;
			end else if (tick_r && hold_r != 5'(`FUNCTION_BUTTON_HOLD_T)) begin
				hold_r <= hold_r + 5'h01;
			end
			// any early release restarts the countdown
			if (!all3) begin
				rest_r <= 6'h00;
			end else if (tick_r && rest_r != 6'(`RESTORE_T)) begin
				rest_r <= rest_r + 6'h01;
			end
		end
	end

	// panel outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			restore_active <= 1'b0;
			restore_left <= 6'h00;
			display_test <= 1'b0;
			det_rst_r <= 1'b0;
		end else begin
			restore_active <= all3;
			restore_left <= all3 ? 6'(`RESTORE_T) - rest_r : 6'h00;
			// two buttons light all segments; three take over
			display_test <= two & !all3;
			det_rst_r <= rst_req;
		end
	end

	// backlight lasts from the last press
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			light_r <= 14'h0000;
			backlight <= 1'b0;
		end else begin
			backlight <= press | (light_r != 14'h0000);
			if (press) begin
				light_r <= 14'(`LIGHT_T);
			end else if (tick_r && light_r != 14'h0000) begin
				light_r <= light_r - 14'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// apb register file
	// ----------------------------------------------------------------
	always_comb begin
		apb_setup = psel & !penable;
		wr_en = psel & penable & pready & pwrite & is_mapped(paddr);
		cfg_wr = pwdata;
		cfg_wr.pad = 4'h0;
		// sensitivity, frequency or filter change resets
		cfg_reset = wr_en && paddr == `OFS_CONFIG && (cfg_wr.sens != cfg_r.sens ||
			cfg_wr.freq != cfg_r.freq || cfg_wr.noise_off != cfg_r.noise_off);
		case (paddr)
			`OFS_CONFIG: rd_nxt = cfg_r;
			`OFS_DIAG: rd_nxt = {29'h0000_0000, diag_r};
			`OFS_STATUS: rd_nxt = {23'h00_0000, green, discon_r, full_sens, tuned,
				alert_r, fail_high, fail_low, loop_fail_msg, call_out};
			`OFS_FAILCNT: rd_nxt = 32'(fail_cnt_r);
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// one wait-free access phase: pready rises in the cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (apb_setup) begin
			pready <= 1'b1;
			pslverr <= !is_mapped(paddr);
			prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// soft resets other than restore keep diagnostics, restore and power reset clear them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= `CONFIG_RST;
			diag_r <= `DIAG_RST;
		end else if (restore_fire) begin
			cfg_r <= `CONFIG_RST;
			diag_r <= `DIAG_RST;
		end else if (wr_en && paddr == `OFS_CONFIG) begin
			cfg_r <= cfg_wr;
		end else if (wr_en && paddr == `OFS_DIAG) begin
			diag_r <= pwdata[2:0];
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_restore_done;
		all3 && tick_r && rest_r == 6'(`RESTORE_T - 1);
	endsequence
	sequence s_soft_reset;
		det_rst_r ##1 tune_r == 9'h000;
	endsequence

	a_green_end_release: assert property ($fell(green) |=> !discon_r)
		else $error("disconnect held after green ended");
	a_discon_blocks_call: assert property (discon_r && !fail_now |=> !call_out)
		else $error("call passed while disconnected");
	a_ext_holds_call: assert property (dis_mode && !cfg_r.dis_type && ext_r != 8'h00
		&& !discon_r |=> call_out)
		else $error("extension did not hold call");
	a_type_on_follows: assert property (dis_mode && cfg_r.dis_type && !det_now
		&& !fail_now |=> !call_out)
		else $error("call not following occupancy");
	a_failsafe_call: assert property (fail_now |=> call_out [*1] ##0 loop_fail_msg)
		else $error("fail-safe call missing");
	a_alert_latched: assert property (fail_rise |=> alert_r ##1 (alert_r || $past(det_rst_r)))
		else $error("alert burst not latched");
	a_fail_count_step: assert property (fail_rise && !det_rst_r && fail_cnt_r != '1
		|=> fail_cnt_r == $past(fail_cnt_r) + FAIL_CNT_W'(1))
		else $error("failure count did not advance");
	a_two_btn_test: assert property (two |=> display_test)
		else $error("display test not shown");
	a_restore_resets: assert property (s_restore_done |=> det_rst_r && cfg_r == `CONFIG_RST)
		else $error("restore did not reset");
	a_reset_untunes: assert property (s_soft_reset |=> !tuned)
		else $error("tuned flag survived reset");
	a_green_abort: assert property (green |=> dly_r == 8'h00)
		else $error("delay ran during green");

endmodule // loop_detector_call_control

// file: logic/loop_det_map.svh
`ifndef LOOP_DET_MAP_SVH
`define LOOP_DET_MAP_SVH
// ----------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define TENTH_NS 100000000
`define TENTH_CYC (`TENTH_NS / `CLK_PERIOD_NS)
`define DEBOUNCE_NS 10000000
`define DEBOUNCE_CYC (`DEBOUNCE_NS / `CLK_PERIOD_NS)
// ----------------------------------------------------------------
// timing counts, in tenths of a second
// ----------------------------------------------------------------
`define FUNCTION_BUTTON_HOLD_S 3
`define FUNCTION_BUTTON_HOLD_T (`FUNCTION_BUTTON_HOLD_S * 10)
`define RESTORE_S 5
`define RESTORE_T (`RESTORE_S * 10)
`define TUNE_S 2
`define TUNE_T (`TUNE_S * 10)
`define FULL_SENS_S 30
`define FULL_SENS_T (`FULL_SENS_S * 10)
`define LIGHT_MIN 15
`define LIGHT_T (`LIGHT_MIN * 600)
`define BURST_S 1
`define BURST_T (`BURST_S * 10)
`define BURST_FLASHES 3
// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define OFS_CONFIG 8'h00
`define OFS_DIAG 8'h04
`define OFS_STATUS 8'h08
`define OFS_FAILCNT 8'h0C
`define OFS_CTRL 8'h10
`define CONFIG_RST 32'h0036_0000
`define DIAG_RST 3'h0
`define CTRL_RESET_BIT 0
`endif

// file: logic/loop_det_pkg.sv
package loop_det_pkg;
	// configuration word, software writable
	typedef struct packed {
		logic [3:0] pad;
		logic green_comp_en;
		logic noise_off;
		logic ext_green_only;
		logic dis_type;
		logic dis_en;
		logic [2:0] freq;
		logic [3:0] sens;
		logic [7:0] delay;
		logic [7:0] ext;
	} cfg_t;
	// diagnostic options that survive a soft reset other than restore
	typedef struct packed {
		logic audible;
		logic delta_disp;
		logic ind_disp;
	} diag_t;
endpackage

// file: bench/loop_partner.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// loop sensor and traffic controller model
// ----------------------------------------------------------------
module loop_partner (
	// clock
	input wire logic pclk,
	// loop measurement and controller pins
	output logic loop_occupied,
	output logic loop_fault_low,
	output logic loop_fault_high,
	output logic phase_green
);
	// empty loop, no green, healthy network at power-up
	initial begin
		loop_occupied = 1'b0;
		loop_fault_low = 1'b0;
		loop_fault_high = 1'b0;
		phase_green = 1'b0;
	end

	// levels move only just after a rising edge, like the real sensor sampling
	task automatic drive(input logic occ, input logic grn, input logic f_lo, input logic f_hi);
		@(posedge pclk);
		loop_occupied <= occ;
		phase_green <= grn;
		loop_fault_low <= f_lo;
		loop_fault_high <= f_hi;
	endtask
endmodule // loop_partner

// file: bench/loop_detector_call_control_bench.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// self-checking bench for the call control block
// ----------------------------------------------------------------
module loop_detector_call_control_bench;
	localparam int TC = 10;
	localparam logic [31:0] CFG_DEF = 32'h0036_0000;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	typedef struct packed {
		logic [31:0] d;
		logic [31:0] m;
		logic e;
	} note_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0] buttons;
	logic phase_green, loop_occupied, loop_fault_low, loop_fault_high;
	logic call_out, detect_led, backlight, display_test, loop_fail_msg;
	logic fail_low, fail_high, restore_active, tuned, retune, full_sens, green_comp, audible;
	logic [5:0] restore_left;
	int err_count;
	int checks;
	note_t notes[$];
	note_t nt;
	logic [7:0] rnd;

	// ----------------------------------------------------------------
	// clock, design and far side
	// ----------------------------------------------------------------
	// 20 MHz clock
	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	// short tenth so second-scale timers fit in the run
	loop_detector_call_control #(.TENTH_CYC(TC), .DEBOUNCE_CYC(2)) u_loop_detector_call_control (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .buttons, .phase_green, .loop_occupied, .loop_fault_low,
		.loop_fault_high, .call_out, .detect_led, .backlight, .display_test,
		.loop_fail_msg, .fail_low, .fail_high, .restore_active, .restore_left, .tuned,
		.full_sens, .green_comp, .audible, .retune);

	loop_partner u_loop_partner (.pclk, .loop_occupied, .loop_fault_low, .loop_fault_high,
		.phase_green);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic stop_test();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic miss(input string s);
		err_count++;
		$display("mismatch at %0t: %s", $time, s);
	endtask

	task automatic chk(input logic got, input logic exp, input string s);
		checks++;
		if (got !== exp) begin
			miss(s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// outputs are looked at mid-cycle, away from the launching edge
	task automatic probe();
		@(negedge pclk);
	endtask

	// one apb transfer, entered just after a rising edge; reads leave a note
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] m, input logic e);
		int n;
		if (!wr) notes.push_back(note_t'{d, m, e});
		// one edge first, so a following call never raises psel where it was released
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) miss("apb answer missing");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// read monitor: takes the oldest note whenever read data is handed over
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
			if (notes.size() == 0) begin
				miss("read without note");
			end else begin
				nt = notes.pop_front();
				checks++;
				if ((prdata & nt.m) !== nt.d || pslverr !== nt.e) begin
					miss("read data or error flag");
				end
			end
		end
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge pclk);
		miss("watchdog expired");
		stop_test();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int n;
		int k;
		int cnt;
		logic prev;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, buttons} = '0;
		rnd = 8'h46;
		err_count = 0;
		checks = 0;
		cyc(5);
		presetn <= 1'b1;
		cyc(1);
		// register reset values and an unmapped place
		apb(1'b0, 8'h00, CFG_DEF, ALL, 1'b0);
		apb(1'b0, 8'h04, 32'h0, ALL, 1'b0);
		apb(1'b0, 8'h14, 32'h0, ALL, 1'b1);
		// no detection until tuning completes
		u_loop_partner.drive(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(20);
		probe();
		chk(call_out, 1'b0, "call before tuning");
		u_loop_partner.drive(1'b0, 1'b0, 1'b0, 1'b0);
		for (n = 0; n < 300 && tuned !== 1'b1; n++) probe();
		chk(tuned, 1'b1, "tuning time");
		cyc(1);
		// delay 5 tenths, extension 3 tenths, no green
		apb(1'b1, 8'h00, 32'h0036_0503, ALL, 1'b0);
		u_loop_partner.drive(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(20);
		probe();
		chk(call_out, 1'b0, "delay not held");
		chk(detect_led, 1'b1, "led during delay");
		for (n = 0; n < 80 && call_out !== 1'b1; n++) probe();
		chk(call_out, 1'b1, "call after delay");
		u_loop_partner.drive(1'b0, 1'b0, 1'b0, 1'b0);
		cyc(15);
		probe();
		chk(call_out, 1'b1, "extension hold");
		chk(detect_led, 1'b1, "led during extension");
		cyc(36);
		probe();
		chk(call_out, 1'b0, "extension end");
		// green present: delay is skipped
		u_loop_partner.drive(1'b0, 1'b1, 1'b0, 1'b0);
		cyc(10);
		u_loop_partner.drive(1'b1, 1'b1, 1'b0, 1'b0);
		cyc(8);
		probe();
		chk(call_out, 1'b1, "green aborts delay");
		u_loop_partner.drive(1'b0, 1'b1, 1'b0, 1'b0);
		cyc(50);
		// disconnect on, type off: extension still runs in green
		apb(1'b1, 8'h00, 32'h00B6_0003, ALL, 1'b0);
		u_loop_partner.drive(1'b1, 1'b1, 1'b0, 1'b0);
		cyc(5);
		u_loop_partner.drive(1'b0, 1'b1, 1'b0, 1'b0);
		cyc(15);
		probe();
		chk(call_out, 1'b1, "gap timer extends");
		cyc(40);
		u_loop_partner.drive(1'b1, 1'b1, 1'b0, 1'b0);
		cyc(10);
		probe();
		chk(call_out, 1'b0, "call after disconnect");
		u_loop_partner.drive(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(12);
		probe();
		chk(call_out, 1'b1, "green off restores call");
		cyc(1);
		// disconnect type on: call follows occupancy until the gap expires
		apb(1'b1, 8'h00, 32'h01B6_0003, ALL, 1'b0);
		u_loop_partner.drive(1'b1, 1'b1, 1'b0, 1'b0);
		cyc(10);
		u_loop_partner.drive(1'b0, 1'b1, 1'b0, 1'b0);
		cyc(5);
		probe();
		chk(call_out, 1'b0, "no extension in type on");
		u_loop_partner.drive(1'b1, 1'b1, 1'b0, 1'b0);
		cyc(5);
		probe();
		chk(call_out, 1'b1, "vehicle within gap");
		u_loop_partner.drive(1'b0, 1'b1, 1'b0, 1'b0);
		cyc(50);
		u_loop_partner.drive(1'b1, 1'b1, 1'b0, 1'b0);
		cyc(5);
		probe();
		chk(call_out, 1'b0, "type on disconnect");
		u_loop_partner.drive(1'b0, 1'b0, 1'b0, 1'b0);
		cyc(20);
		// short loop, then open loop, each healing by itself
		for (k = 0; k < 2; k++) begin
			u_loop_partner.drive(1'b0, 1'b0, k == 0, k == 1);
			cyc(20);
			probe();
			chk(call_out, 1'b1, "fail-safe call");
			chk(loop_fail_msg, 1'b1, "failure message");
			chk(fail_low, k == 0, "low fault kind");
			chk(fail_high, k == 1, "high fault kind");
			u_loop_partner.drive(1'b0, 1'b0, 1'b0, 1'b0);
			cyc(3);
			probe();
			chk(loop_fail_msg, 1'b0, "self heal");
		end
		cyc(1);
		apb(1'b0, 8'h0C, 32'h2, ALL, 1'b0);
		apb(1'b0, 8'h08, 32'h10, 32'h0000_0013, 1'b0);
		// any 100-cycle window holds exactly three flashes
		cnt = 0;
		prev = detect_led;
		for (n = 0; n < 10 * TC; n++) begin
			probe();
			if (detect_led === 1'b1 && prev === 1'b0) cnt++;
			prev = detect_led;
		end
		chk(cnt == 3, 1'b1, "burst flash count");
		cyc(1);
		// random diagnostic options, then a manual reset
		rnd = lfsr(rnd);
		apb(1'b1, 8'h04, {29'h0, rnd[2:0]}, ALL, 1'b0);
		apb(1'b1, 8'h10, 32'h1, ALL, 1'b0);
		for (n = 0; n < 10 && retune !== 1'b1; n++) probe();
		chk(retune, 1'b1, "manual reset");
		cyc(1);
		apb(1'b0, 8'h04, {29'h0, rnd[2:0]}, ALL, 1'b0);
		apb(1'b0, 8'h0C, 32'h0, ALL, 1'b0);
		apb(1'b0, 8'h08, 32'h0, 32'h10, 1'b0);
		// audible option follows bare occupancy
		u_loop_partner.drive(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(2);
		probe();
		chk(audible, rnd[2], "audible follows occupancy");
		u_loop_partner.drive(1'b0, 1'b0, 1'b0, 1'b0);
		// function button held 3 s
		buttons <= 3'b001;
		for (n = 0; n < 400 && retune !== 1'b1; n++) probe();
		chk(retune, 1'b1, "button reset");
		chk(n >= 30 * TC - 10, 1'b1, "button hold time");
		chk(backlight, 1'b1, "backlight on press");
		cyc(1);
		// two buttons, then all three
		buttons <= 3'b110;
		cyc(10);
		probe();
		chk(display_test, 1'b1, "two-button test");
		cyc(1);
		buttons <= 3'b111;
		cyc(10);
		probe();
		chk(display_test, 1'b0, "restore precedence");
		chk(restore_active, 1'b1, "restore countdown");
		chk(restore_left == 6'h32 || restore_left == 6'h31, 1'b1, "countdown value");
		cyc(100);
		buttons <= 3'b000;
		cyc(10);
		apb(1'b0, 8'h00, 32'h01B6_0003, ALL, 1'b0);
		buttons <= 3'b111;
		cyc(50 * TC + 60);
		buttons <= 3'b000;
		cyc(10);
		apb(1'b0, 8'h00, CFG_DEF, ALL, 1'b0);
		// filter change resets; green compensation and green-only extension on
		apb(1'b1, 8'h00, 32'h0E36_0003, ALL, 1'b0);
		for (n = 0; n < 10 && retune !== 1'b1; n++) probe();
		chk(retune, 1'b1, "filter change reset");
		u_loop_partner.drive(1'b0, 1'b1, 1'b1, 1'b0);
		cyc(10);
		probe();
		chk(green_comp, 1'b1, "green compensation");
		u_loop_partner.drive(1'b0, 1'b0, 1'b0, 1'b0);
		chk(full_sens, 1'b0, "full sensitivity early");
		for (n = 0; n < 3100 && full_sens !== 1'b1; n++) probe();
		chk(full_sens, 1'b1, "full sensitivity");
		cyc(1);
		// no extension outside green with the green-only option
		u_loop_partner.drive(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(5);
		u_loop_partner.drive(1'b0, 1'b0, 1'b0, 1'b0);
		cyc(3);
		probe();
		chk(call_out, 1'b0, "extension outside green");
		cyc(1);
		// power loss clears the diagnostic options
		apb(1'b1, 8'h04, 32'h7, ALL, 1'b0);
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
		cyc(1);
		apb(1'b0, 8'h04, 32'h0, ALL, 1'b0);
		cyc(5);
		stop_test();
	end
endmodule // loop_detector_call_control_bench
